/* File: hw/swtc_top.sv */
/*
 * scan watchdog, scan-time statistics, one time-shared timer slot and one
 * time-shared counter slot; the watchdog and scan-time statistics sit behind a simple register port.
 * assumes a 10 MHz clock, synchronous inputs and a program sequencer that
 * pulses scan_start once per scan and evaluates timers/counters in order.
 */
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "swtc_params.svh"

module swtc_top (
  input  wire logic              clk,          // 10 MHz system clock
  input  wire logic              sys_rst,      // async reset, active high
  input  wire logic              clk_en,       // freezes all state when low
  input  wire swtc_pkg::swtc_bus_t bus,        // register port
  output logic [31:0]            rdata,        // read data, cycle after rd
  input  wire logic              scan_start,   // pulse at step 0 of a scan
  input  wire logic              watchdog_restart_request, // clears wd time
  input  wire logic              manual_reset, // front reset switch
  input  wire logic              stop_mode,    // mode switch at STOP
  input  wire logic              power_fail,   // supply below limit
  input  wire swtc_pkg::swtc_tmr_req_t tmr,    // timer evaluation
  input  wire swtc_pkg::swtc_cnt_req_t cnt,    // counter evaluation
  output logic                   run_ok,       // program may execute
  output logic                   outputs_en,   // low forces outputs off
  output logic                   wd_error,     // latched watchdog error
  output logic                   restart_req,  // full restart pending
  output logic [31:0]            tmr_elapsed,  // timer elapsed ms
  output logic                   tmr_q,        // timer output
  output logic [31:0]            current_count,// counter value
  output logic                   cnt_q,        // counter output, 0 in up/down mode
  output logic                   upper_reached_output, // count >= preset
  output logic                   lower_reached_output  // count <= preset
);
  import swtc_pkg::*;

  localparam logic [13:0] TICK_LAST = 14'(`SWTC_TICK_CYC - 1);
  localparam logic [4:0]  PF_LIM    = 5'(`SWTC_PFAIL_MS);
  localparam logic [31:0] MAX32     = 32'hffffffff;
  localparam logic [15:0] MAX16     = 16'hffff;

  swtc_state_t s_r, s_nxt;

  // saturating helpers, used by several counters
  function automatic logic [31:0] sat_inc32(input logic [31:0] v);
    sat_inc32 = (v == MAX32) ? v : v + 32'h1;
  endfunction : sat_inc32

  function automatic logic [15:0] sat_inc16(input logic [15:0] v);
    sat_inc16 = (v == MAX16) ? v : v + 16'h1;
  endfunction : sat_inc16

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  always_comb begin
    logic cu_rise;
    logic cd_rise;
    logic clr_err;
    logic [31:0] cv;
    cu_rise = 1'b0;
    cd_rise = 1'b0;
    clr_err = 1'b0;
    cv      = 32'h0;
    s_nxt   = s_r;
    s_nxt.tick = 1'b0;

    // 1 ms time base
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = 14'h0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 14'h1;
    end

    // register writes; writing 0 to the limit is taken as 1
    if (bus.wr) begin
      case (bus.addr)
        `SWTC_A_CTRL:     s_nxt.run_en = bus.wdata[`SWTC_CTRL_RUN];
        `SWTC_A_WD_LIMIT: s_nxt.wd_limit = (bus.wdata[15:0] == 16'h0) ? 16'h1 : bus.wdata[15:0];
        default: ;
      endcase
    end

    // power-fail length measured in ms; long outage demands a restart
    if (power_fail) begin
      if (s_r.tick && s_r.pf_ms != 5'h1f)
        s_nxt.pf_ms = s_r.pf_ms + 5'h1;
      if (s_r.pf_ms > PF_LIM)
        s_nxt.pf_long = 1'b1;
    end else begin
      s_nxt.pf_ms = 5'h0;
    end

    // run state machine
    // a long outage that ends while halted is a restart as well
    clr_err = manual_reset | stop_mode | s_r.restarted | (s_r.pf_long & ~power_fail);
    case (s_r.run)
      SWTC_ST_IDLE: begin
        s_nxt.restarted = 1'b0;
        if (s_r.run_en && !stop_mode && !power_fail)
          s_nxt.run = SWTC_ST_RUN;
      end
      SWTC_ST_RUN: begin
        if (power_fail) begin
          s_nxt.run = SWTC_ST_RUN;                        // held, output retained
        end else if (s_r.pf_long) begin
          s_nxt.pf_long   = 1'b0;
          s_nxt.restarted = 1'b1;
          s_nxt.run       = SWTC_ST_IDLE;
          s_nxt.scan_seen = 1'b0;
          s_nxt.wd_elapsed = 16'h0;
        end else if (stop_mode || !s_r.run_en) begin
          s_nxt.run = SWTC_ST_IDLE;
        end
        if (s_r.wd_elapsed > s_r.wd_limit) begin
          s_nxt.run    = SWTC_ST_HALT;
          s_nxt.wd_err = 1'b1;
        end
      end
      SWTC_ST_HALT: begin
        if (clr_err) begin
          s_nxt.wd_err = 1'b0;
          // power back after a long outage: full restart, not a resume
          if (s_r.pf_long && !power_fail) begin
            s_nxt.pf_long   = 1'b0;
            s_nxt.restarted = 1'b1;
            s_nxt.scan_seen = 1'b0;
          end
          s_nxt.run    = SWTC_ST_IDLE;
          s_nxt.wd_elapsed = 16'h0;
        end
      end
      default: s_nxt.run = SWTC_ST_IDLE;
    endcase
    s_nxt.outputs_en = (s_nxt.run != SWTC_ST_HALT);

    // watchdog elapsed time and scan accumulation
    if (s_r.run == SWTC_ST_RUN) begin
      if (watchdog_restart_request || scan_start)
        s_nxt.wd_elapsed = 16'h0;
      else if (s_r.tick)
        s_nxt.wd_elapsed = sat_inc16(s_r.wd_elapsed);
      if (scan_start) begin
        s_nxt.scan_acc  = 16'h0;
        s_nxt.scan_seen = 1'b1;
        if (s_r.scan_seen) begin
          s_nxt.scan_time_current = s_r.scan_acc;
          if (s_r.scan_acc > s_r.scan_max)
            s_nxt.scan_max = s_r.scan_acc;
          if (s_r.scan_acc < s_r.scan_min)
            s_nxt.scan_min = s_r.scan_acc;
        end
      end else if (s_r.tick) begin
        s_nxt.scan_acc = sat_inc16(s_r.scan_acc);
      end
    end

    // timer slot: only touched when the program evaluates it
    if (tmr.eval && s_r.run == SWTC_ST_RUN) begin
      s_nxt.tmr_in_d = tmr.in;
      case (tmr.mode)
        SWTC_TMR_ON_DELAY: begin
          if (!tmr.in) begin
            s_nxt.tmr_elapsed = 32'h0;
            s_nxt.tmr_q       = 1'b0;
          end else begin
            if (s_r.tmr_elapsed < tmr.preset_value && s_r.tick)
              s_nxt.tmr_elapsed = sat_inc32(s_r.tmr_elapsed);
            s_nxt.tmr_q = (s_nxt.tmr_elapsed == tmr.preset_value);
          end
        end
        SWTC_TMR_OFF_DELAY: begin
          if (tmr.in) begin
            s_nxt.tmr_q       = 1'b1;
            s_nxt.tmr_elapsed = 32'h0;
          end else if (s_r.tmr_q) begin
            if (s_r.tick)
              s_nxt.tmr_elapsed = sat_inc32(s_r.tmr_elapsed);
            if (s_nxt.tmr_elapsed >= tmr.preset_value)
              s_nxt.tmr_q = 1'b0;
          end
        end
        SWTC_TMR_PULSE: begin
          if (!s_r.tmr_active && tmr.in && !s_r.tmr_in_d) begin
            s_nxt.tmr_active  = 1'b1;
            s_nxt.tmr_q       = 1'b1;
            s_nxt.tmr_elapsed = 32'h0;
          end else if (s_r.tmr_active) begin
            if (s_r.tick)
              s_nxt.tmr_elapsed = sat_inc32(s_r.tmr_elapsed);
            if (s_nxt.tmr_elapsed >= tmr.preset_value) begin
              s_nxt.tmr_q      = 1'b0;
              s_nxt.tmr_active = 1'b0;
            end
          end
        end
        default: s_nxt.tmr_q = 1'b0;
      endcase
    end

    // counter slot: edges against the level seen at the previous evaluation
    if (cnt.eval && s_r.run == SWTC_ST_RUN) begin
      cu_rise = cnt.count_up_input & ~s_r.cu_d;
      cd_rise = cnt.count_down_input & ~s_r.cd_d;
      s_nxt.cu_d = cnt.count_up_input;
      s_nxt.cd_d = cnt.count_down_input;
      cv = s_r.current_count;
      case (cnt.mode)
        SWTC_CNT_UP: begin
          if (cnt.reset)
            cv = 32'h0;
          else if (cu_rise)
            cv = sat_inc32(cv);
          s_nxt.cnt_q = !cnt.reset && (cv >= cnt.preset_value);
        end
        SWTC_CNT_DOWN: begin
          if (cnt.preset_load_input)
            cv = cnt.preset_value;
          else if (cd_rise && cv != 32'h0)
            cv = cv - 32'h1;
          s_nxt.cnt_q = !cnt.preset_load_input && (cv == 32'h0);
        end
        SWTC_CNT_UPDOWN: begin
          if (cnt.reset)
            cv = 32'h0;
          else if (cnt.preset_load_input)
            cv = cnt.preset_value;
          else if (cu_rise && !cd_rise)
            cv = sat_inc32(cv);
          else if (cd_rise && !cu_rise && cv != 32'h0)
            cv = cv - 32'h1;
          s_nxt.cnt_q = 1'b0;
        end
        default: ;
      endcase
      s_nxt.current_count = cv;
      s_nxt.upper_reached_output = (cv >= cnt.preset_value);
      s_nxt.lower_reached_output = (cv <= cnt.preset_value);
    end

    // read data, valid only the cycle after the strobe
    s_nxt.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        `SWTC_A_CTRL:      s_nxt.rdata = {31'h0, s_r.run_en};
        `SWTC_A_WD_LIMIT:  s_nxt.rdata = {16'h0, s_r.wd_limit};
        `SWTC_A_STATUS:    s_nxt.rdata = {29'h0, s_r.restarted, (s_r.run == SWTC_ST_RUN), s_r.wd_err};
        `SWTC_A_SCAN_MAX:  s_nxt.rdata = {16'h0, s_r.scan_max};
        `SWTC_A_SCAN_MIN:  s_nxt.rdata = {16'h0, s_r.scan_min};
        `SWTC_A_SCAN_TIME_CURRENT:  s_nxt.rdata = {16'h0, s_r.scan_time_current};
        `SWTC_A_WD_ELAPSE: s_nxt.rdata = {16'h0, s_r.wd_elapsed};
        default:           s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r          <= '0;
      s_r.run      <= SWTC_ST_IDLE;
      s_r.wd_limit <= `SWTC_WD_LIMIT_RST;
      s_r.scan_min <= 16'hffff;
      s_r.outputs_en <= 1'b1;
      s_r.lower_reached_output <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign rdata                = s_r.rdata;
  assign run_ok               = (s_r.run == SWTC_ST_RUN);
  assign outputs_en           = s_r.outputs_en;
  assign wd_error             = s_r.wd_err;
  assign restart_req          = s_r.restarted;
  assign tmr_elapsed          = s_r.tmr_elapsed;
  assign tmr_q                = s_r.tmr_q;
  assign current_count        = s_r.current_count;
  assign cnt_q                = s_r.cnt_q;
  assign upper_reached_output = s_r.upper_reached_output;
  assign lower_reached_output = s_r.lower_reached_output;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wd_halt_outputs: assert property (clk_en && s_r.run == SWTC_ST_RUN && s_r.wd_elapsed > s_r.wd_limit
      |=> !outputs_en && wd_error)
    else $error("watchdog overrun did not halt");
  a_wd_restart_zero: assert property (clk_en && s_r.run == SWTC_ST_RUN && watchdog_restart_request
      && !(s_r.wd_elapsed > s_r.wd_limit) |=> s_r.wd_elapsed == 16'h0)
    else $error("restart request left elapsed time");
  a_err_hold: assert property (wd_error && !manual_reset && !stop_mode && !s_r.restarted
      |=> wd_error)
    else $error("watchdog error cleared without cause");
  a_limit_nonzero: assert property (s_r.wd_limit != 16'h0)
    else $error("watchdog limit zero");
  a_scan_order: assert property (s_r.scan_seen && s_r.scan_min != 16'hffff
      |-> s_r.scan_min <= s_r.scan_max)
    else $error("minimum above maximum");
  a_updown_cmp: assert property (cnt.eval && clk_en && run_ok && cnt.mode == SWTC_CNT_UPDOWN
      |=> upper_reached_output == (current_count >= $past(cnt.preset_value)))
    else $error("upper output mismatch");
  a_reset_wins: assert property (cnt.eval && clk_en && run_ok && cnt.mode == SWTC_CNT_UPDOWN && cnt.reset
      |=> current_count == 32'h0)
    else $error("reset did not clear count");
  a_level_no_count: assert property (cnt.eval && clk_en && run_ok && cnt.mode == SWTC_CNT_UP && !cnt.reset
      && s_r.cu_d && cnt.count_up_input |=> $stable(current_count))
    else $error("counted on steady level");
  a_tmr_frozen: assert property (!tmr.eval |=> $stable(tmr_elapsed))
    else $error("timer moved without evaluation");
  a_err_manual_clear: assert property (clk_en && wd_error && (manual_reset || stop_mode)
      |=> !wd_error && outputs_en)
    else $error("watchdog error not cleared");
  a_pf_restart: assert property (clk_en && run_ok && s_r.pf_long && !power_fail
      && !(s_r.wd_elapsed > s_r.wd_limit) |=> restart_req && !run_ok)
    else $error("long outage did not restart");
  a_up_reset: assert property (cnt.eval && clk_en && run_ok && cnt.mode == SWTC_CNT_UP && cnt.reset
      |=> current_count == 32'h0 && !cnt_q)
    else $error("up counter reset failed");
  a_down_load: assert property (cnt.eval && clk_en && run_ok && cnt.mode == SWTC_CNT_DOWN && cnt.preset_load_input
      |=> current_count == $past(cnt.preset_value) && !cnt_q)
    else $error("down counter load failed");

  c_wd_trip:   cover property (run_ok ##1 wd_error);
  c_scan_done: cover property (run_ok && scan_start && s_r.scan_seen);
  c_pulse_end: cover property (tmr_q ##1 !tmr_q);
  c_restart:   cover property (restart_req);
  c_man_clear: cover property (wd_error && manual_reset);

endmodule : swtc_top
`default_nettype wire

/* File: hw/swtc_params.svh */
/*
 * constants of the scan watchdog / timer / counter unit: offsets of the
 * register port, field positions, reset values and timing counts.
 * assumes a 10 MHz clock and inclusion by bare name.
 */
`ifndef SWTC_PARAMS_SVH
`define SWTC_PARAMS_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define SWTC_A_CTRL      8'h00
`define SWTC_A_WD_LIMIT  8'h04
`define SWTC_A_STATUS    8'h08
`define SWTC_A_SCAN_MAX  8'h0c
`define SWTC_A_SCAN_MIN  8'h10
`define SWTC_A_SCAN_TIME_CURRENT  8'h14
`define SWTC_A_WD_ELAPSE 8'h18

// ***********************************************************
// control / status fields
// ***********************************************************
`define SWTC_CTRL_RUN    0
`define SWTC_ST_WD_ERR   0
`define SWTC_ST_RUNNING  1
`define SWTC_ST_RESTART  2

// ***********************************************************
// reset values and timing
// ***********************************************************
`define SWTC_WD_LIMIT_RST 16'h00c8
`define SWTC_CLK_HZ       10000000
`define SWTC_TICK_MS      1
`define SWTC_TICK_CYC     (`SWTC_CLK_HZ / 1000 * `SWTC_TICK_MS)
`define SWTC_PFAIL_MS     20

`endif

/* File: hw/swtc_pkg.sv */
/*
 * types of the scan watchdog / timer / counter unit.
 * assumes swtc_params.svh is available on the include path.
 */
package swtc_pkg;

  typedef enum logic [1:0] {
    SWTC_TMR_ON_DELAY,
    SWTC_TMR_OFF_DELAY,
    SWTC_TMR_PULSE
  } swtc_tmr_mode_t;

  typedef enum logic [1:0] {
    SWTC_CNT_UP,
    SWTC_CNT_DOWN,
    SWTC_CNT_UPDOWN
  } swtc_cnt_mode_t;

  typedef enum logic [1:0] {
    SWTC_ST_IDLE,
    SWTC_ST_RUN,
    SWTC_ST_HALT
  } swtc_run_t;

  // one timer evaluation request from the sequence program
  typedef struct packed {
    logic           eval;
    logic           in;
    swtc_tmr_mode_t mode;
    logic [31:0]    preset_value;
  } swtc_tmr_req_t;

  // one counter evaluation request
  typedef struct packed {
    logic           eval;
    swtc_cnt_mode_t mode;
    logic           count_up_input;
    logic           count_down_input;
    logic           reset;
    logic           preset_load_input;
    logic [31:0]    preset_value;
  } swtc_cnt_req_t;

  // register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } swtc_bus_t;

  typedef struct packed {
    swtc_run_t   run;
    logic        wd_err;
    logic        restarted;
    logic        run_en;
    logic [15:0] wd_limit;
    logic [15:0] wd_elapsed;
    logic [15:0] scan_max;
    logic [15:0] scan_min;
    logic [15:0] scan_time_current;
    logic [15:0] scan_acc;
    logic        scan_seen;
    logic [13:0] tick_cnt;
    logic        tick;
    logic [4:0]  pf_ms;
    logic        pf_long;
    logic [31:0] tmr_elapsed;
    logic        tmr_in_d;
    logic        tmr_active;
    logic        tmr_q;
    logic [31:0] current_count;
    logic        cu_d;
    logic        cd_d;
    logic        cnt_q;
    logic        upper_reached_output;
    logic        lower_reached_output;
    logic        outputs_en;
    logic [31:0] rdata;
  } swtc_state_t;

endpackage : swtc_pkg

/* File: dv/swtc_prog_model.sv */
/*
 * user program model: scan-start pulses and watchdog restart requests.
 * assumes the 10 MHz bench clock and the unit's active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module swtc_prog_model #(
  parameter int SLOT_CYC = 5000                  // half a millisecond per slot
) (
  input  wire logic clk,                         // system clock
  input  wire logic sys_rst,                     // async reset
  input  wire logic scan_en,                     // emit scan starts
  input  wire logic kick_en,                     // emit restart requests
  output logic      scan_start,                  // step 0 pulse
  output logic      watchdog_restart_request     // restart pulse
);
  // ***********************************************************
  // slot sequencer
  // ***********************************************************
  logic [15:0] slot_r;
  logic [1:0]  phase_r;

  // a scan spans three slots; a restart each slot keeps elapsed time below two ticks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_r                   <= 16'h0000;
      phase_r                  <= 2'h0;
      scan_start               <= 1'b0;
      watchdog_restart_request <= 1'b0;
    end else begin
      scan_start               <= 1'b0;
      watchdog_restart_request <= 1'b0;
      if (slot_r == 16'(SLOT_CYC - 1)) begin
        slot_r                   <= 16'h0000;
        phase_r                  <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
        scan_start               <= scan_en && (phase_r == 2'h2);
        watchdog_restart_request <= kick_en;
      end else begin
        slot_r <= slot_r + 16'h0001;
      end
    end
  end
endmodule : swtc_prog_model

`default_nettype wire

/* File: dv/test_scan_watchdog_timer_counter.sv */
/*
 * self-checking bench of the scan watchdog / timer / counter unit.
 * assumes swtc_pkg, swtc_params.svh and the program model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "swtc_params.svh"

module test_scan_watchdog_timer_counter;
  import swtc_pkg::*;
  // ***********************************************************
  // signals and instances
  // ***********************************************************
  logic           clk, sys_rst, scan_start, wrr, scan_en, kick_en, stop_mode, manual_reset, power_fail;
  swtc_bus_t      bus;
  swtc_tmr_req_t  tmr;
  swtc_cnt_req_t  cnt;
  swtc_cnt_mode_t md;
  logic [31:0]    rdata, tmr_elapsed, current_count, rd_v, exp_c, lf;
  logic           run_ok, outputs_en, wd_error, restart_req, tmr_q, cnt_q, upr, lwr, pu, pd;
  int             failures, check_count, n;

  swtc_top dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus), .rdata(rdata),
    .scan_start(scan_start), .watchdog_restart_request(wrr), .manual_reset(manual_reset),
    .stop_mode(stop_mode), .power_fail(power_fail), .tmr(tmr), .cnt(cnt), .run_ok(run_ok),
    .outputs_en(outputs_en), .wd_error(wd_error), .restart_req(restart_req),
    .tmr_elapsed(tmr_elapsed), .tmr_q(tmr_q), .current_count(current_count), .cnt_q(cnt_q),
    .upper_reached_output(upr), .lower_reached_output(lwr));

  swtc_prog_model #(.SLOT_CYC(5000)) prog (.clk(clk), .sys_rst(sys_rst), .scan_en(scan_en),
    .kick_en(kick_en), .scan_start(scan_start), .watchdog_restart_request(wrr));

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic results();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd_reg

  // expected count worked out from the previous evaluation's input levels
  task automatic cnt_op(input swtc_cnt_mode_t m, input logic u, input logic d, input logic r,
                        input logic l, input logic [31:0] pv);
    logic ur, dr;
    ur = u & ~pu;
    dr = d & ~pd;
    pu = u;
    pd = d;
    if (r && m != SWTC_CNT_DOWN) exp_c = 32'h0;
    else if (l && m != SWTC_CNT_UP) exp_c = pv;
    else if (ur && !(m == SWTC_CNT_UPDOWN && dr) && m != SWTC_CNT_DOWN && exp_c != 32'hffffffff)
      exp_c = exp_c + 32'h1;
    else if (dr && !(m == SWTC_CNT_UPDOWN && ur) && m != SWTC_CNT_UP && exp_c != 32'h0)
      exp_c = exp_c - 32'h1;
    @(posedge clk);
    cnt <= '{eval: 1'b1, mode: m, count_up_input: u, count_down_input: d, reset: r,
             preset_load_input: l, preset_value: pv};
    @(posedge clk);
    cnt.eval <= 1'b0;
    #1;
    chk(current_count, exp_c);
    if (m == SWTC_CNT_UPDOWN) chk({cnt_q, upr, lwr}, {1'b0, exp_c >= pv, exp_c <= pv});
    else chk(cnt_q, (m == SWTC_CNT_UP) ? exp_c >= pv : exp_c == 32'h0);
  endtask : cnt_op

  // timer evaluated every cycle so that no millisecond tick is missed
  task automatic tmr_set(input logic i, input swtc_tmr_mode_t m);
    @(posedge clk);
    tmr <= '{eval: 1'b1, in: i, mode: m, preset_value: 32'h1};
    @(posedge clk);
    #1;
  endtask : tmr_set

  task automatic wait_for(input logic on_wd, input logic lvl);
    n = 0;
    while (((on_wd ? wd_error : tmr_q) !== lvl) && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 30000, 1'b1);
  endtask : wait_for

  // ***********************************************************
  // clock, reset, watchdog
  // ***********************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole sequence needs about 90k cycles
  initial begin
    #12000000;
    failures++;
    results();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    sys_rst = 1'b1; bus = '0; tmr = '0; cnt = '0;
    scan_en = 1'b1; kick_en = 1'b0; stop_mode = 1'b0; manual_reset = 1'b0; power_fail = 1'b0;
    failures = 0; check_count = 0; pu = 1'b0; pd = 1'b0; exp_c = 32'h0; lf = 32'd70572;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({outputs_en, wd_error, run_ok}, 3'b100);
    rd_reg(`SWTC_A_WD_LIMIT, rd_v);
    chk(rd_v, 32'h000000c8);
    rd_reg(`SWTC_A_SCAN_MIN, rd_v);
    chk(rd_v, 32'h0000ffff);
    rd_reg(8'h1c, rd_v);
    chk(rd_v, 32'h0);
    wr_reg(`SWTC_A_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(run_ok, 1'b1);
    // counters: clean start, then random levels held one evaluation each
    for (int m = 0; m < 3; m++) begin
      md = swtc_cnt_mode_t'(m);
      cnt_op(md, 1'b0, 1'b0, md != SWTC_CNT_DOWN, md == SWTC_CNT_DOWN, 32'h5);
      for (int i = 0; i < 24; i++) begin
        lf = lfsr_next(lf);
        cnt_op(md, lf[0], lf[1], md != SWTC_CNT_DOWN && lf[6:4] == 3'h0,
               md != SWTC_CNT_UP && lf[9:7] == 3'h0, {29'h0, lf[12:10]} | 32'h1);
      end
    end
    cnt_op(SWTC_CNT_UPDOWN, 1'b0, 1'b0, 1'b1, 1'b1, 32'h9);
    cnt_op(SWTC_CNT_UPDOWN, 1'b0, 1'b0, 1'b0, 1'b1, 32'hffffffff);
    cnt_op(SWTC_CNT_UPDOWN, 1'b1, 1'b0, 1'b0, 1'b0, 32'hffffffff);
    cnt_op(SWTC_CNT_DOWN, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1);
    cnt_op(SWTC_CNT_DOWN, 1'b0, 1'b1, 1'b0, 1'b0, 32'h1);
    cnt_op(SWTC_CNT_DOWN, 1'b0, 1'b0, 1'b0, 1'b0, 32'h1);
    cnt_op(SWTC_CNT_DOWN, 1'b0, 1'b1, 1'b0, 1'b0, 32'h1);
    // timers with a one millisecond preset
    tmr_set(1'b1, SWTC_TMR_ON_DELAY);
    wait_for(1'b0, 1'b1);
    chk(tmr_elapsed, 32'h1);
    tmr_set(1'b0, SWTC_TMR_ON_DELAY);
    chk(tmr_q, 1'b0);
    tmr_set(1'b1, SWTC_TMR_OFF_DELAY);
    chk(tmr_q, 1'b1);
    tmr_set(1'b0, SWTC_TMR_OFF_DELAY);
    chk(tmr_q, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(tmr_elapsed, 32'h1);
    tmr_set(1'b1, SWTC_TMR_PULSE);
    tmr_set(1'b0, SWTC_TMR_PULSE);
    chk(tmr_q, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(tmr_elapsed, 32'h1);
    // scans of 1.5 ms read back as one or two milliseconds
    rd_reg(`SWTC_A_SCAN_TIME_CURRENT, rd_v);
    chk(rd_v == 32'h1 || rd_v == 32'h2, 1'b1);
    rd_reg(`SWTC_A_SCAN_MAX, exp_c);
    rd_reg(`SWTC_A_SCAN_MIN, lf);
    chk(lf >= 32'h1 && lf <= rd_v && exp_c >= rd_v && exp_c <= 32'h2, 1'b1);
    // watchdog: restarts hold off a 1 ms limit, then it trips
    kick_en <= 1'b1;
    scan_en <= 1'b0;
    repeat (6000) @(posedge clk);
    wr_reg(`SWTC_A_WD_LIMIT, 32'hffff);
    rd_reg(`SWTC_A_WD_LIMIT, rd_v);
    chk(rd_v, 32'h0000ffff);
    wr_reg(`SWTC_A_WD_LIMIT, 32'h0);
    rd_reg(`SWTC_A_WD_LIMIT, rd_v);
    chk(rd_v, 32'h1);
    // a short outage holds the run state and asks for no restart
    @(posedge clk);
    power_fail <= 1'b1;
    repeat (100) @(posedge clk);
    #1 chk(run_ok, 1'b1);
    @(posedge clk);
    power_fail <= 1'b0;
    repeat (15000) @(posedge clk);
    #1 chk({wd_error, run_ok, restart_req}, 3'b010);
    rd_reg(`SWTC_A_STATUS, rd_v);
    chk(rd_v, 32'h2);
    rd_reg(`SWTC_A_WD_ELAPSE, rd_v);
    chk(rd_v <= 32'h1, 1'b1);
    kick_en <= 1'b0;
    wait_for(1'b1, 1'b1);
    chk({outputs_en, run_ok}, 2'b00);
    rd_reg(`SWTC_A_STATUS, rd_v);
    chk(rd_v, 32'h1);
    repeat (50) @(posedge clk);
    #1 chk(wd_error, 1'b1);
    // manual reset clears the error, the unit runs again and trips again
    @(posedge clk);
    manual_reset <= 1'b1;
    repeat (3) @(posedge clk);
    manual_reset <= 1'b0;
    #1 chk({wd_error, outputs_en, run_ok}, 3'b011);
    wait_for(1'b1, 1'b1);
    chk(outputs_en, 1'b0);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(wd_error, 1'b0);
    results();
  end
endmodule : test_scan_watchdog_timer_counter

`default_nettype wire
